// file: bd_status_pkg.sv
// Package with descriptor status layout, PIDs, handshakes and register map.
//
// Functional notes
// [RULE1] Status bit 7 is the ownership semaphore.
// [RULE2] Core leaves engine-owned descriptors untouched.
// [RULE3] Core writes status byte last when arming.
// [RULE4] Engine releases ownership unless keep or stall.
// [RULE5] Engine overwrites status with PID and count.
// [RULE6] No hardware blocking of core accesses; the controller drops writes to engine-owned descriptors.
// [RULE7] Keep bit: hold ownership, no queue, no interrupt.
// [RULE8] Keep bit meant only for streaming port use.
// [RULE9] Address step inhibit reuses one buffer location.
// [RULE10] Toggle check compares packet parity with bit 6.
// [RULE11] Toggle mismatch: ACK, discard, keep, status unchanged.
// [RULE12] SETUP accepted despite toggle mismatch.
// [RULE13] Toggle check off: accept either, release, update.
// [RULE14] Errored OUT: NAK, keep, nothing updated.
// [RULE15] Stall bit: STALL handshake, stall seen, interrupt.
// [RULE16] Stall holds until SETUP returns ownership to core.
// [RULE17] Count bits 9:8 in status 1:0, range 0-1023.
// [RULE18] Firmware sets ownership before enabling module.
package bd_status_pkg;

  // ****************************************************************
  // Status byte fields
  // ****************************************************************
  localparam int OWN_BIT    = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int KEEP_BIT   = 5;
  localparam int INHIBIT_BIT = 4;
  localparam int CHECK_BIT  = 3;
  localparam int STALL_BIT  = 2;
  localparam int PID_LSB    = 2;
  localparam int COUNT_MAX  = 1023;

  // ****************************************************************
  // Token and handshake codes
  // ****************************************************************
  localparam logic [3:0] PID_OUT   = 4'h1;
  localparam logic [3:0] PID_IN    = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hd;

  typedef enum logic [1:0] {HS_ACK = 2'h0, HS_NAK = 2'h1, HS_STALL = 2'h2} handshake_t;

  // ****************************************************************
  // Controller register map (word offsets in bytes) and resets
  // ****************************************************************
  localparam logic [3:0] REG_STATUS   = 4'h0;
  localparam logic [3:0] REG_COUNT    = 4'h4;
  localparam logic [3:0] REG_IRQ      = 4'h8;
  localparam logic [3:0] REG_MASK     = 4'hc;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET   = 3'h0;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_STALL = 1;
  localparam int IRQ_ARMED = 2;

endpackage : bd_status_pkg

// file: bd_link_if.sv
// Interface joining the core-side controller and the serial link engine.
`timescale 1ns/1ns
`default_nettype none
interface bd_link_if;
  import bd_status_pkg::*;
  logic       coreWr;
  logic [7:0] coreStatus;
  logic [7:0] coreCount;
  logic [7:0] engStatus;
  logic [7:0] engCount;
  logic       tokValid;
  logic [3:0] tokPid;
  logic       tokToggle;
  logic       tokError;
  logic [9:0] tokLen;
  logic       hsValid;
  handshake_t hsCode;
  logic       dataWrite;
  logic       addrStep;
  logic       queuePush;
  logic       doneFlag;
  logic       stallSeen;

  modport engine (input coreWr, coreStatus, coreCount, tokValid, tokPid, tokToggle, tokError, tokLen,
                  output engStatus, engCount, hsValid, hsCode, dataWrite, addrStep, queuePush,
                  doneFlag, stallSeen);
  modport core (output coreWr, coreStatus, coreCount,
                input engStatus, engCount, doneFlag, stallSeen);
endinterface : bd_link_if
`default_nettype wire

// file: bd_sticky_bit.sv
// One sticky interrupt bit with set-over-clear priority.
`timescale 1ns/1ns
`default_nettype none
module bd_sticky_bit
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Control
  input  wire logic setEvt,
  input  wire logic clrReq,
  output logic      flag_q
);
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      flag_q <= 1'b0;
    else if (setEvt)
      flag_q <= 1'b1;
    else if (clrReq)
      flag_q <= 1'b0;
  end
endmodule : bd_sticky_bit
`default_nettype wire

// file: bd_engine.sv
// Serial link engine end: descriptor status interpretation and update.
`timescale 1ns/1ns
`default_nettype none
module bd_engine
  import bd_status_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Link side
  bd_link_if.engine lnk
);
  logic [7:0] stat_q;
  logic [7:0] cnt_q;
  logic       hsValid_q;
  handshake_t hsCode_q;
  logic       dataWrite_q;
  logic       addrStep_q;
  logic       push_q;
  logic       done_q;
  logic       stall_q;

  // ****************************************************************
  // Decode of one token against the descriptor
  // ****************************************************************
  wire owned     = stat_q[OWN_BIT];                              // see [RULE1]
  wire keepOn    = stat_q[KEEP_BIT];
  wire stallOn   = stat_q[STALL_BIT];
  wire isSetup   = lnk.tokPid == PID_SETUP;
  wire isIn      = lnk.tokPid == PID_IN;
  wire tokOk     = lnk.tokValid && owned;
  wire tooLong   = !isIn && lnk.tokLen > {stat_q[1:0], cnt_q};
  wire badRx     = !isIn && (lnk.tokError || tooLong);           // see [RULE14]
  wire mismatch  = stat_q[CHECK_BIT] && !isIn && !isSetup
                   && (lnk.tokToggle != stat_q[TOGGLE_BIT]);     // see [RULE10] [RULE12] [RULE13]
  wire doStall   = tokOk && stallOn && !isSetup;                 // see [RULE15]
  wire stallClr  = tokOk && stallOn && isSetup;                  // see [RULE16]
  wire accept    = tokOk && !stallOn && !badRx && !mismatch;
  wire retire    = (accept && !keepOn) || stallClr;              // see [RULE4] [RULE7]
  wire [7:0] newStat = {!retire, 1'b0, lnk.tokPid, lnk.tokLen[9:8]}; // see [RULE5] [RULE17]

  // Core writes land here regardless of ownership; only the controller drops them while the engine owns the descriptor.
  always_ff @(posedge core_clk or negedge reset_n)               // see [RULE6]
  begin
    if (!reset_n)
    begin
      stat_q <= STATUS_RESET;
      cnt_q  <= 8'h00;
    end
    else if (lnk.coreWr)
    begin
      stat_q <= lnk.coreStatus;
      cnt_q  <= lnk.coreCount;
    end
    else if (accept && !keepOn || stallClr)
    begin
      stat_q <= newStat;
      cnt_q  <= lnk.tokLen[7:0];
    end
  end

  // ****************************************************************
  // Handshake and event outputs
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hsValid_q   <= 1'b0;
      hsCode_q    <= HS_ACK;
      dataWrite_q <= 1'b0;
      addrStep_q  <= 1'b0;
      push_q      <= 1'b0;
      done_q      <= 1'b0;
      stall_q     <= 1'b0;
    end
    else
    begin
      hsValid_q   <= lnk.tokValid;
      hsCode_q    <= !owned ? HS_NAK : doStall ? HS_STALL : (badRx ? HS_NAK : HS_ACK); // see [RULE11]
      dataWrite_q <= accept && !isIn;
      addrStep_q  <= accept && !stat_q[INHIBIT_BIT];             // see [RULE9]
      push_q      <= retire;
      done_q      <= retire;
      stall_q     <= doStall;
    end
  end

  assign lnk.engStatus = stat_q;
  assign lnk.engCount  = cnt_q;
  assign lnk.hsValid   = hsValid_q;
  assign lnk.hsCode    = hsCode_q;
  assign lnk.dataWrite = dataWrite_q;
  assign lnk.addrStep  = addrStep_q;
  assign lnk.queuePush = push_q;
  assign lnk.doneFlag  = done_q;
  assign lnk.stallSeen = stall_q;
endmodule : bd_engine
`default_nettype wire

// file: bd_core_ctrl.sv
// Core-side controller: AXI4-Lite registers that arm descriptors and report events.
`timescale 1ns/1ns
`default_nettype none
module bd_core_ctrl
  import bd_status_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Interrupt
  output logic             irq,
  // Link side
  bd_link_if.core          lnk
);
  logic        awHave_q, wHave_q, bvalid_q, rvalid_q, arready_q, irq_q;
  logic        awready_q, wready_q;
  logic [3:0]  awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [7:0]  pendStat_q, pendCnt_q;
  logic        coreWr_q;
  logic [2:0]  mask_q;
  logic [2:0]  flags;

  // ****************************************************************
  // Write path
  // ****************************************************************
  wire doWrite  = awHave_q && wHave_q && !bvalid_q;
  wire wrStat   = doWrite && awAddr_q == REG_STATUS;
  wire wrCnt    = doWrite && awAddr_q == REG_COUNT;
  wire wrIrq    = doWrite && awAddr_q == REG_IRQ;
  wire wrMask   = doWrite && awAddr_q == REG_MASK;
  wire wrMapped = wrStat || wrCnt || wrIrq || wrMask;
  // Count is staged; the status write launches both, so ownership lands last.
  wire launch   = wrStat;                                        // see [RULE3]
  wire armed    = lnk.engStatus[OWN_BIT];
  // Writes to an engine-owned descriptor are dropped by the controller.
  wire allowed  = !armed;                                        // see [RULE2]

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awAddr_q <= 4'h0;
      wData_q  <= 32'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !awHave_q)
      begin
        awHave_q <= 1'b1;
        awready_q <= 1'b0;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_q)
      begin
        wHave_q <= 1'b1;
        wready_q <= 1'b0;
        wData_q <= s_axi_wdata;
      end
      if (doWrite)
      begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q  <= wrMapped ? 2'h0 : 2'h2;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pendStat_q <= STATUS_RESET;
      pendCnt_q  <= 8'h00;
      coreWr_q   <= 1'b0;
      mask_q     <= MASK_RESET;
    end
    else
    begin
      coreWr_q <= launch && allowed;
      if (launch && allowed)
        pendStat_q <= wData_q[7:0];
      if (wrCnt && allowed)
        pendCnt_q <= wData_q[7:0];
      if (wrMask)
        mask_q <= wData_q[2:0];
    end
  end

  // ****************************************************************
  // Interrupt status: done, stall, and descriptor returned to core
  // ****************************************************************
  logic armed_q;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      armed_q <= 1'b0;
    else
      armed_q <= armed;
  end
  wire [2:0] evts = {armed_q && !armed, lnk.stallSeen, lnk.doneFlag};
  for (genvar i = 0; i < 3; i++)
  begin : g_flag
    bd_sticky_bit u_bit
    (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .setEvt   (evts[i]),
      .clrReq   (wrIrq && wData_q[i]),
      .flag_q   (flags[i])
    );
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_q <= 1'b0;
    else
      irq_q <= |(flags & mask_q);
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire [31:0] rdMux = (s_axi_araddr == REG_STATUS) ? {24'h0, lnk.engStatus} :
                      (s_axi_araddr == REG_COUNT)  ? {24'h0, lnk.engCount}  :
                      (s_axi_araddr == REG_IRQ)    ? {29'h0, flags}         :
                      (s_axi_araddr == REG_MASK)   ? {29'h0, mask_q}        : 32'h0;
  wire rdMapped = s_axi_araddr == REG_STATUS || s_axi_araddr == REG_COUNT ||
                  s_axi_araddr == REG_IRQ || s_axi_araddr == REG_MASK;
  wire rdTake   = s_axi_arvalid && arready_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
    end
    else
    begin
      arready_q <= !rvalid_q && !rdTake;
      if (rdTake)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rdMux;
        rresp_q  <= rdMapped ? 2'h0 : 2'h2;
      end
      else if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
  assign irq            = irq_q;
  assign lnk.coreWr     = coreWr_q;
  assign lnk.coreStatus = pendStat_q;
  assign lnk.coreCount  = pendCnt_q;
endmodule : bd_core_ctrl
`default_nettype wire

// file: bd_link_chk.sv
// Concurrent checks on the link between the core controller and the engine.
`timescale 1ns/1ns
`default_nettype none
module bd_link_chk
  import bd_status_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  // Core side
  input wire logic       coreWr,
  input wire logic [7:0] coreStatus,
  // Engine side
  input wire logic [7:0] engStatus,
  input wire logic [7:0] engCount,
  input wire logic       tokValid,
  input wire logic [3:0] tokPid,
  input wire logic       tokToggle,
  input wire logic       tokError,
  input wire logic [9:0] tokLen,
  input wire logic       hsValid,
  input wire handshake_t hsCode,
  input wire logic       addrStep,
  input wire logic       dataWrite,
  input wire logic       queuePush,
  input wire logic       doneFlag,
  input wire logic       stallSeen
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  wire owned   = engStatus[OWN_BIT];
  wire stall   = engStatus[STALL_BIT];
  wire same    = tokToggle == engStatus[TOGGLE_BIT];
  wire checkOn = engStatus[CHECK_BIT];
  // IN tokens bring no bytes in, so the length limit, receive errors and the toggle check pass them by.
  wire rxBad   = tokPid != PID_IN && (tokError || tokLen > {engStatus[1:0], engCount});
  wire clean   = tokValid && owned && !stall && !rxBad;
  wire take    = clean && (!checkOn || same || tokPid == PID_SETUP || tokPid == PID_IN);

  sequence s_hs(handshake_t c);
    hsValid && hsCode == c;
  endsequence

  a_core_blocked: assert property (coreWr |-> !owned) else $error("core loaded an owned descriptor");
  a_load_status: assert property (coreWr |=> engStatus == $past(coreStatus)) else $error("status not loaded");
  a_idle_nak: assert property (tokValid && !owned |=> s_hs(HS_NAK) ##0 !doneFlag) else $error("idle token taken");
  a_error_nak:
    assert property (tokValid && owned && !stall && rxBad |=> s_hs(HS_NAK) ##0 $stable(engStatus) && !queuePush)
    else $error("errored packet not refused");
  a_stall_answer:
    assert property (tokValid && owned && stall && !tokError && tokPid != PID_SETUP
                     |=> s_hs(HS_STALL) ##0 stallSeen && $stable(engStatus)) else $error("stall not answered");
  a_stall_clear:
    assert property (tokValid && owned && stall && !rxBad && tokPid == PID_SETUP |=> s_hs(HS_ACK) ##0 !owned)
    else $error("setup did not clear stall");
  a_toggle_drop:
    assert property (clean && checkOn && !same && tokPid == PID_OUT
                     |=> s_hs(HS_ACK) ##0 $stable(engStatus) && !dataWrite && !doneFlag) else $error("bad toggle used");
  a_keep_hold:
    assert property (take && engStatus[KEEP_BIT] |=> s_hs(HS_ACK) ##0 $stable(engStatus) && !doneFlag && !queuePush)
    else $error("kept descriptor changed");
  a_accept_update:
    assert property (take && !engStatus[KEEP_BIT] |=> s_hs(HS_ACK) ##0 doneFlag && queuePush
                     && engStatus == {2'h0, $past(tokPid), $past(tokLen[9:8])} && engCount == $past(tokLen[7:0]))
    else $error("accepted token not recorded");
  a_step_off: assert property (tokValid && owned && engStatus[INHIBIT_BIT] |=> !addrStep [*2]) else $error("step");
endmodule : bd_link_chk
`default_nettype wire

// file: usb_buffer_descriptor_status_tb.sv
// Testbench joining the core controller and the engine over the descriptor link.
`timescale 1ns/1ns
`default_nettype none
module usb_buffer_descriptor_status_tb
  import bd_status_pkg::*;
;
  logic        core_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] seed = 16'hdd2a;
  logic [9:0]  lenFloor = 10'h000;
  logic [65:0] readQ[$];
  logic [1:0]  respQ[$];
  handshake_t  hsQ[$];
  int          num_errors = 0;
  int          comparisons = 0;

  bd_link_if lnk();
  bd_core_ctrl i_bd_core_ctrl (.core_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq, .lnk(lnk));
  bd_engine i_bd_engine (.core_clk, .reset_n, .lnk(lnk));
  bd_link_chk i_bd_link_chk (.core_clk, .reset_n, .coreWr(lnk.coreWr), .coreStatus(lnk.coreStatus),
    .engStatus(lnk.engStatus), .engCount(lnk.engCount), .tokValid(lnk.tokValid), .tokPid(lnk.tokPid),
    .tokToggle(lnk.tokToggle), .tokError(lnk.tokError), .tokLen(lnk.tokLen), .hsValid(lnk.hsValid),
    .hsCode(lnk.hsCode), .addrStep(lnk.addrStep), .dataWrite(lnk.dataWrite), .queuePush(lnk.queuePush),
    .doneFlag(lnk.doneFlag), .stallSeen(lnk.stallSeen));

  always #25 core_clk = ~core_clk;

  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nextRand

  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    respQ.push_back(r);
    @(posedge core_clk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [1:0] r, input logic [31:0] care, input logic [31:0] d);
    readQ.push_back({r, care, d});
    @(posedge core_clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic irqIs(input logic e);
    repeat (2) @(posedge core_clk);
    check(irq, e, "irq");
  endtask : irqIs

  // Arms the descriptor (ignored while the engine owns it), sends one token and reads the descriptor back.
  task automatic run(input logic [7:0] arm, input logic [3:0] pid, input logic tog, input logic err,
                     input handshake_t hs, input logic upd);
    logic [9:0] len;
    seed = nextRand(seed);
    len = seed[9:0] | lenFloor;
    wr(REG_COUNT, 32'hff, 2'h0);
    wr(REG_STATUS, {24'h0, arm}, 2'h0);
    repeat (2) @(posedge core_clk);
    hsQ.push_back(hs);
    lnk.tokValid  <= 1'h1;
    lnk.tokPid    <= pid;
    lnk.tokToggle <= tog;
    lnk.tokError  <= err;
    lnk.tokLen    <= len;
    @(posedge core_clk);
    lnk.tokValid <= 1'h0;
    rd(REG_STATUS, 2'h0, 32'hff, upd ? {24'h0, 2'h0, pid, len[9:8]} : {24'h0, arm});
    if (upd) rd(REG_COUNT, 2'h0, 32'hff, {24'h0, len[7:0]});
    $display("test done: token %h on descriptor %h", pid, arm);
  endtask : run

  always @(posedge core_clk)
  begin
    logic [65:0] e;
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = readQ.pop_front();
      check({s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]}, "read");
    end
    if (s_axi_bvalid && s_axi_bready)
      check(s_axi_bresp, respQ.pop_front(), "write response");
    if (lnk.hsValid)
      check(lnk.hsCode, hsQ.pop_front(), "handshake");
  end

  initial
  begin
    #300000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    logic [3:0] pids[3];
    pids = '{PID_OUT, PID_IN, PID_SETUP};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    {lnk.tokValid, lnk.tokPid, lnk.tokToggle, lnk.tokError, lnk.tokLen} = 17'h0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'h1;
    rd(REG_STATUS, 2'h0, 32'hffffffff, 32'h0);
    rd(REG_MASK, 2'h0, 32'hffffffff, 32'h0);
    rd(4'h1, 2'h2, 32'hffffffff, 32'h0);
    wr(4'h1, 32'h0, 2'h2);
    run(8'h00, PID_IN, 1'h0, 1'h0, HS_NAK, 1'h0);
    foreach (pids[i])
    begin
      seed = nextRand(seed);
      run({1'h1, seed[5], 6'h03}, pids[i], seed[6], 1'h0, HS_ACK, 1'h1);
    end
    irqIs(1'h0);
    rd(REG_IRQ, 2'h0, 32'h7, 32'h5);
    wr(REG_MASK, 32'h3, 2'h0);
    irqIs(1'h1);
    wr(REG_IRQ, 32'h7, 2'h0);
    irqIs(1'h0);
    run(8'hcb, PID_OUT, 1'h0, 1'h0, HS_ACK, 1'h0);
    run(8'hcb, PID_OUT, 1'h1, 1'h0, HS_ACK, 1'h1);
    run(8'h8b, PID_SETUP, 1'h1, 1'h0, HS_ACK, 1'h1);
    run(8'h83, PID_OUT, seed[2], 1'h1, HS_NAK, 1'h0);
    run(8'h83, PID_OUT, 1'h0, 1'h0, HS_ACK, 1'h1);
    // The floor pushes the OUT length past the armed limit of 0x1ff, so it must be refused.
    lenFloor = 10'h200;
    run(8'h81, PID_OUT, 1'h0, 1'h0, HS_NAK, 1'h0);
    lenFloor = 10'h000;
    run(8'h81, PID_IN, 1'h0, 1'h0, HS_ACK, 1'h1);
    wr(REG_IRQ, 32'h7, 2'h0);
    run(8'h87, PID_IN, 1'h0, 1'h0, HS_STALL, 1'h0);
    rd(REG_IRQ, 2'h0, 32'h3, 32'h2);
    run(8'h87, PID_SETUP, 1'h0, 1'h0, HS_ACK, 1'h1);
    run(8'h93, PID_OUT, 1'h0, 1'h0, HS_ACK, 1'h1);
    wr(REG_IRQ, 32'h7, 2'h0);
    run(8'ha3, PID_OUT, 1'h0, 1'h0, HS_ACK, 1'h0);
    run(8'ha3, PID_IN, 1'h0, 1'h0, HS_ACK, 1'h0);
    rd(REG_IRQ, 2'h0, 32'h1, 32'h0);
    wr(REG_STATUS, 32'h0, 2'h0);
    rd(REG_STATUS, 2'h0, 32'hff, 32'ha3);
    repeat (4) @(posedge core_clk);
    check(hsQ.size(), 34'h0, "pending handshakes");
    end_sim();
  end
endmodule : usb_buffer_descriptor_status_tb
`default_nettype wire
